/* File: design/dcp_core.sv */
// Overview of operation
// - Each edge acts on previous and current clock enable plus the held state.
// - Clock enable low twice holds power-down or self refresh; commands ignored.
// - Enable falling with NOP/deselect enters active or precharge power-down.
// - Refresh with enable falling enters self refresh, only with all banks idle.
// - No refresh happens in power-down; controller bounds its length.
// - No termination in self refresh; termination pin never alters power state.
// - Enable high twice: commands decode by the normal command table.
// - Write beats with mask low are stored; mask high leaves location unchanged.
// - Chip select high accepts no new command; running work continues.
// - NOP starts nothing new; running work continues.
// - Mode register set picks register by bank address, loads from address.
// - Activate opens the row until the bank is precharged.
`default_nettype none
`include "dcp_regs.svh"
module dcp_core
  import dcp_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Command pins, sampled on the same clock
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [`DCP_BA_W-1:0] ba,
  input wire logic [`DCP_ADDR_W-1:0] addr,
  input wire logic odt,
  // Write data beat
  input wire logic wr_beat,
  input wire logic dm,
  input wire logic [`DCP_DQ_W-1:0] wr_data,
  input wire logic [`DCP_COL_W-1:0] wr_col,
  // Array write port
  output logic arr_we,
  output logic [`DCP_COL_W-1:0] arr_col,
  output logic [`DCP_DQ_W-1:0] arr_data,
  // Status
  output dcp_state_type state,
  output logic [`DCP_NUM_BANKS-1:0] bank_open,
  output logic odt_active,
  output logic read_ok,
  output logic [`DCP_ADDR_W-1:0] mode_reg0,
  output logic [`DCP_ADDR_W-1:0] mode_reg1,
  output logic [`DCP_ADDR_W-1:0] mode_reg2,
  output logic [`DCP_ADDR_W-1:0] mode_reg3
);
  logic cke_prev;
  logic next_cke_prev;
  dcp_state_type next_state;
  dcp_cmd_type cmd;
  logic [7:0] xsrd_cnt;
  logic [7:0] next_xsrd_cnt;
  logic [`DCP_ADDR_W-1:0] mr [`DCP_MR_COUNT];
  logic [`DCP_ADDR_W-1:0] next_mr [`DCP_MR_COUNT];
  logic next_arr_we;
  logic [`DCP_COL_W-1:0] next_arr_col;
  logic [`DCP_DQ_W-1:0] next_arr_data;
  logic executes;
  logic any_open;
  logic [`DCP_NUM_BANKS-1:0] act_vec;
  logic [`DCP_NUM_BANKS-1:0] pre_vec;

  // Command decode; chip select high masks the strobes
  always_comb begin
    cmd = DCP_CMD_NOP;
    if (cs_n) begin
      cmd = DCP_CMD_DESEL;
    end else begin
      case ({ras_n, cas_n, we_n})
        3'h0: cmd = DCP_CMD_MRS;
        3'h1: cmd = DCP_CMD_REF;
        3'h2: cmd = DCP_CMD_PRE;
        3'h3: cmd = DCP_CMD_ACT;
        3'h4: cmd = DCP_CMD_WR;
        3'h5: cmd = DCP_CMD_RD;
        3'h7: cmd = DCP_CMD_NOP;
        default: cmd = DCP_CMD_NOP;
      endcase
    end
  end

  // Commands execute only with enable high at both edges
  assign executes = cke_prev && cke;
  assign any_open = |bank_open;

  // Per-bank activate and precharge strobes
  always_comb begin
    act_vec = '0;
    pre_vec = '0;
    if (executes && cmd == DCP_CMD_ACT) begin
      act_vec[ba] = 1'b1;
    end
    if (executes && cmd == DCP_CMD_PRE) begin
      if (addr[10]) begin
        pre_vec = '1;
      end else begin
        pre_vec[ba] = 1'b1;
      end
    end
  end

  // Row trackers, one per bank
  for (genvar b = 0; b < `DCP_NUM_BANKS; b++) begin : g_bank
    dcp_bank u_bank (
      .ref_clk(ref_clk),
      .srst(srst),
      .act(act_vec[b]),
      .pre(pre_vec[b]),
      .row_in(addr),
      .open(bank_open[b]),
      .row()
    );
  end

  // Power state transitions from both enable samples
  always_comb begin
    next_state = state;
    next_cke_prev = cke;
    next_xsrd_cnt = xsrd_cnt;
    case (state)
      DCP_ST_IDLE, DCP_ST_ACTIVE: begin
        if (cke_prev && !cke) begin
          if (cmd == DCP_CMD_REF && !any_open) begin
            next_state = DCP_ST_SELF_REF;
          end else if (any_open) begin
            next_state = DCP_ST_ACT_PD;
          end else begin
            next_state = DCP_ST_PRE_PD;
          end
        end else begin
          next_state = any_open ? DCP_ST_ACTIVE : DCP_ST_IDLE;
          if (executes && cmd == DCP_CMD_ACT) begin
            next_state = DCP_ST_ACTIVE;
          end
        end
        if (xsrd_cnt != 8'h00) begin
          next_xsrd_cnt = xsrd_cnt - 8'h01;
        end
      end
      DCP_ST_PRE_PD, DCP_ST_ACT_PD: begin
        // Low twice holds; rising exits; refresh not run here
        if (cke) begin
          next_state = any_open ? DCP_ST_ACTIVE : DCP_ST_IDLE;
        end
      end
      DCP_ST_SELF_REF: begin
        if (cke) begin
          next_state = DCP_ST_IDLE;
          next_xsrd_cnt = 8'(`DCP_XSRD_CLK);
        end
      end
      default: next_state = DCP_ST_IDLE;
    endcase
  end

  // Power state registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state <= DCP_ST_IDLE;
      cke_prev <= 1'b1;
      xsrd_cnt <= 8'h00;
    end else begin
      state <= next_state;
      cke_prev <= next_cke_prev;
      xsrd_cnt <= next_xsrd_cnt;
    end
  end

  assign read_ok = (xsrd_cnt == 8'h00);
  // Termination follows the pin except in self refresh
  assign odt_active = odt && (state != DCP_ST_SELF_REF);

  // Mode register load selected by bank address
  always_comb begin
    for (int i = 0; i < `DCP_MR_COUNT; i++) begin
      next_mr[i] = mr[i];
    end
    if (executes && cmd == DCP_CMD_MRS) begin
      next_mr[ba[1:0]] = addr;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      for (int i = 0; i < `DCP_MR_COUNT; i++) begin
        mr[i] <= `DCP_MR_RESET;
      end
    end else begin
      for (int i = 0; i < `DCP_MR_COUNT; i++) begin
        mr[i] <= next_mr[i];
      end
    end
  end

  assign mode_reg0 = mr[0];
  assign mode_reg1 = mr[1];
  assign mode_reg2 = mr[2];
  assign mode_reg3 = mr[3];

  // Masked write beats leave the array untouched
  always_comb begin
    next_arr_we = wr_beat && !dm;
    next_arr_col = wr_beat ? wr_col : arr_col;
    next_arr_data = (wr_beat && !dm) ? wr_data : arr_data;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      arr_we <= 1'b0;
      arr_col <= '0;
      arr_data <= '0;
    end else begin
      arr_we <= next_arr_we;
      arr_col <= next_arr_col;
      arr_data <= next_arr_data;
    end
  end

  // Checks
  property p_pd_hold;
    @(posedge ref_clk) disable iff (srst)
      (state inside {DCP_ST_PRE_PD, DCP_ST_ACT_PD} && !cke) |=> (state == $past(state));
  endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("power-down not held");

  property p_pd_entry;
    @(posedge ref_clk) disable iff (srst)
      (state inside {DCP_ST_IDLE, DCP_ST_ACTIVE} && cke_prev && !cke
       && cmd inside {DCP_CMD_NOP, DCP_CMD_DESEL})
      |=> (state == ($past(any_open) ? DCP_ST_ACT_PD : DCP_ST_PRE_PD));
  endproperty
  a_pd_entry: assert property (p_pd_entry) else $error("bad power-down entry");

  property p_sr_entry;
    @(posedge ref_clk) disable iff (srst)
      (state == DCP_ST_IDLE && cke_prev && !cke && cmd == DCP_CMD_REF && !any_open)
      |=> state == DCP_ST_SELF_REF;
  endproperty
  a_sr_entry: assert property (p_sr_entry) else $error("self refresh not entered");

  property p_xsrd;
    @(posedge ref_clk) disable iff (srst)
      (state == DCP_ST_SELF_REF && cke) |=> !read_ok [*8];
  endproperty
  a_xsrd: assert property (p_xsrd) else $error("read allowed too early");

  property p_no_odt_sr;
    @(posedge ref_clk) disable iff (srst)
      state == DCP_ST_SELF_REF |-> !odt_active;
  endproperty
  a_no_odt_sr: assert property (p_no_odt_sr) else $error("termination in self refresh");

  property p_deselect;
    @(posedge ref_clk) disable iff (srst)
      (cs_n && state == DCP_ST_IDLE && cke_prev && cke)
      |=> (bank_open == $past(bank_open) && state == DCP_ST_IDLE);
  endproperty
  a_deselect: assert property (p_deselect) else $error("deselect changed state");

  property p_mrs;
    @(posedge ref_clk) disable iff (srst)
      (executes && cmd == DCP_CMD_MRS && ba[1:0] == 2'h1) |=> mode_reg1 == $past(addr);
  endproperty
  a_mrs: assert property (p_mrs) else $error("mode register not loaded");

  property p_act;
    @(posedge ref_clk) disable iff (srst)
      (executes && cmd == DCP_CMD_ACT && !pre_vec[ba]) |=> bank_open[$past(ba)];
  endproperty
  a_act: assert property (p_act) else $error("row not opened");

  property p_mask;
    @(posedge ref_clk) disable iff (srst)
      (wr_beat && dm) |=> !arr_we;
  endproperty
  a_mask: assert property (p_mask) else $error("masked beat written");

  // Leaving power-down returns to the state that matches the open banks
  property p_pd_exit;
    @(posedge ref_clk) disable iff (srst)
      (state inside {DCP_ST_PRE_PD, DCP_ST_ACT_PD} && cke)
      |=> (state == ($past(any_open) ? DCP_ST_ACTIVE : DCP_ST_IDLE));
  endproperty
  a_pd_exit: assert property (p_pd_exit) else $error("bad power-down exit");

  property p_sr_hold;
    @(posedge ref_clk) disable iff (srst)
      (state == DCP_ST_SELF_REF && !cke) |=> state == DCP_ST_SELF_REF;
  endproperty
  a_sr_hold: assert property (p_sr_hold) else $error("self refresh not held");

  // A no-operation must leave rows and mode register 0 alone
  property p_nop;
    @(posedge ref_clk) disable iff (srst)
      (!cs_n && ras_n && cas_n && we_n)
      |=> (bank_open == $past(bank_open) && mode_reg0 == $past(mode_reg0));
  endproperty
  a_nop: assert property (p_nop) else $error("no-operation changed state");

  c_sr: cover property (@(posedge ref_clk) disable iff (srst)
    state == DCP_ST_SELF_REF ##1 state == DCP_ST_IDLE);
  c_apd: cover property (@(posedge ref_clk) disable iff (srst) state == DCP_ST_ACT_PD);
  c_ppd: cover property (@(posedge ref_clk) disable iff (srst) state == DCP_ST_PRE_PD);
  c_rdok: cover property (@(posedge ref_clk) disable iff (srst) $rose(read_ok));
endmodule : dcp_core
`default_nettype wire

/* File: design/dcp_regs.svh */
`ifndef DCP_REGS_SVH
`define DCP_REGS_SVH
// Geometry
`define DCP_NUM_BANKS 8
`define DCP_BA_W 3
`define DCP_ADDR_W 14
`define DCP_DQ_W 8
`define DCP_COL_W 10
`define DCP_MR_COUNT 4
// Self refresh exit to first read, in clocks
`define DCP_XSRD_CLK 200
// Least registrations of a clock-enable level
`define DCP_CKE_MIN_CLK 3
// Reset values
`define DCP_MR_RESET 14'h0000
`define DCP_ROW_RESET 14'h0000
`endif

/* File: design/dcp_pkg.sv */
`default_nettype none
`include "dcp_regs.svh"
package dcp_pkg;
  // Power state held before each edge
  typedef enum logic [2:0] {
    DCP_ST_IDLE,
    DCP_ST_ACTIVE,
    DCP_ST_PRE_PD,
    DCP_ST_ACT_PD,
    DCP_ST_SELF_REF
  } dcp_state_type;
  // Decoded command
  typedef enum logic [3:0] {
    DCP_CMD_DESEL,
    DCP_CMD_NOP,
    DCP_CMD_MRS,
    DCP_CMD_REF,
    DCP_CMD_PRE,
    DCP_CMD_ACT,
    DCP_CMD_WR,
    DCP_CMD_RD
  } dcp_cmd_type;
endpackage : dcp_pkg
`default_nettype wire

/* File: design/dcp_bank.sv */
`default_nettype none
`include "dcp_regs.svh"
// One bank: open row tracker
module dcp_bank
  import dcp_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Commands to this bank
  input wire logic act,
  input wire logic pre,
  input wire logic [`DCP_ADDR_W-1:0] row_in,
  // State
  output logic open,
  output logic [`DCP_ADDR_W-1:0] row
);
  logic next_open;
  logic [`DCP_ADDR_W-1:0] next_row;

  // Open on activate, close on precharge
  always_comb begin
    next_open = open;
    next_row = row;
    if (act && !open) begin
      next_open = 1'b1;
      next_row = row_in;
    end else if (pre) begin
      next_open = 1'b0;
    end
  end

  // Register row state
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      open <= 1'b0;
      row <= `DCP_ROW_RESET;
    end else begin
      open <= next_open;
      row <= next_row;
    end
  end
endmodule : dcp_bank
`default_nettype wire

/* File: tb/dcp_ctrl_model.sv */
`default_nettype none
`include "dcp_regs.svh"
// Controller side: turns bench requests into command pins
module dcp_ctrl_model
  import dcp_pkg::*;
(
  // Requests
  input wire logic ref_clk,
  input wire dcp_cmd_type cmd,
  input wire logic cke_req,
  input wire logic odt_req,
  input wire logic [`DCP_BA_W-1:0] ba_req,
  input wire logic [`DCP_ADDR_W-1:0] addr_req,
  // Pins
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [`DCP_BA_W-1:0] ba,
  output logic [`DCP_ADDR_W-1:0] addr,
  output logic odt
);
  logic flip;
  logic cke_last;
  logic hold_low;
  logic dont_care;
  // Pattern that changes every cycle on lines the device must ignore
  initial flip = 1'b0;
  always @(negedge ref_clk) flip <= ~flip;
  initial cke_last = 1'b1;
  always @(posedge ref_clk) cke_last <= cke;
  // Bench keeps each level at least three steps and requests one mode set in low power
  assign cke = cke_req;
  assign odt = odt_req;
  assign hold_low = !cke_req && !cke_last;
  assign dont_care = hold_low || (cmd == DCP_CMD_DESEL);
  assign ba = dont_care ? {`DCP_BA_W{flip}} : ba_req;
  assign addr = dont_care ? {`DCP_ADDR_W{flip}} : addr_req;
  // Command encoding
  always_comb begin
    {cs_n, ras_n, cas_n, we_n} = 4'hF;
    case (cmd)
      DCP_CMD_NOP: cs_n = 1'b0;
      DCP_CMD_MRS: {cs_n, ras_n, cas_n, we_n} = 4'h0;
      DCP_CMD_REF: {cs_n, ras_n, cas_n, we_n} = 4'h1;
      DCP_CMD_PRE: {cs_n, ras_n, cas_n, we_n} = 4'h2;
      DCP_CMD_ACT: {cs_n, ras_n, cas_n, we_n} = 4'h3;
      DCP_CMD_WR: {cs_n, ras_n, cas_n, we_n} = 4'h4;
      DCP_CMD_RD: {cs_n, ras_n, cas_n, we_n} = 4'h5;
      default: ;
    endcase
    // Ignored lines decode as mode set or activate, so any leak shows up
    if (dont_care) begin
      {ras_n, cas_n, we_n} = {1'b0, flip, flip};
    end
    if (hold_low) begin
      cs_n = ~flip;
    end
  end
endmodule : dcp_ctrl_model
`default_nettype wire

/* File: tb/tb.sv */
`default_nettype none
`include "dcp_regs.svh"
module tb
  import dcp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  dcp_cmd_type cmd = DCP_CMD_NOP;
  logic cke_req = 1'b1;
  logic odt_req = 1'b0;
  logic [`DCP_BA_W-1:0] ba_req = 3'h0;
  logic [`DCP_ADDR_W-1:0] addr_req = 14'h0000;
  logic cke, cs_n, ras_n, cas_n, we_n, odt;
  logic [`DCP_BA_W-1:0] ba;
  logic [`DCP_ADDR_W-1:0] addr;
  logic wr_beat = 1'b0;
  logic dm = 1'b0;
  logic [`DCP_DQ_W-1:0] wr_data = 8'h00;
  logic [`DCP_COL_W-1:0] wr_col = 10'h000;
  logic arr_we, odt_active, read_ok;
  logic [`DCP_COL_W-1:0] arr_col;
  logic [`DCP_DQ_W-1:0] arr_data;
  dcp_state_type state;
  logic [`DCP_NUM_BANKS-1:0] bank_open;
  logic [`DCP_ADDR_W-1:0] mode_reg0, mode_reg1, mode_reg2, mode_reg3;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  // Clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  dcp_ctrl_model i_ctrl (.ref_clk(ref_clk), .cmd(cmd), .cke_req(cke_req), .odt_req(odt_req),
    .ba_req(ba_req), .addr_req(addr_req), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .odt(odt));
  dcp_core i_dut (.ref_clk(ref_clk), .srst(srst), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .odt(odt), .wr_beat(wr_beat), .dm(dm),
    .wr_data(wr_data), .wr_col(wr_col), .arr_we(arr_we), .arr_col(arr_col),
    .arr_data(arr_data), .state(state), .bank_open(bank_open), .odt_active(odt_active),
    .read_ok(read_ok), .mode_reg0(mode_reg0), .mode_reg1(mode_reg1), .mode_reg2(mode_reg2),
    .mode_reg3(mode_reg3));
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test
  // Hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk
  // One command cycle, outputs settled after the edge
  task automatic step(input dcp_cmd_type c, input logic k, input logic [2:0] b,
    input logic [13:0] a);
    @(negedge ref_clk);
    cmd = c;
    cke_req = k;
    ba_req = b;
    addr_req = a;
    @(posedge ref_clk);
    #1;
  endtask : step
  task automatic hold(input logic k, input int n);
    repeat (n) step(DCP_CMD_NOP, k, 3'h0, 14'h0000);
  endtask : hold
  task automatic beat(input logic m, input logic [7:0] d, input logic [9:0] c);
    @(negedge ref_clk);
    wr_beat = 1'b1;
    dm = m;
    wr_data = d;
    wr_col = c;
    @(posedge ref_clk);
    #1;
    chk("arr_we", 64'(arr_we), 64'(!m));
    if (!m) chk("arr_wr", 64'({arr_col, arr_data}), 64'({c, d}));
  endtask : beat
  task automatic t_mrs();
    for (int i = 0; i < 4; i++) begin
      step(DCP_CMD_MRS, 1'b1, 3'(i), 14'h0100 + 14'(i));
      hold(1'b1, 2);
    end
    step(DCP_CMD_DESEL, 1'b1, 3'h0, 14'h0000);
    chk("mode", 64'({mode_reg3, mode_reg2, mode_reg1, mode_reg0}),
      64'({14'h0103, 14'h0102, 14'h0101, 14'h0100}));
    $display("t_mrs done");
  endtask : t_mrs
  task automatic t_pd();
    step(DCP_CMD_ACT, 1'b1, 3'h2, 14'h1234);
    hold(1'b1, 2);
    chk("open", 64'({state, bank_open}), 64'({DCP_ST_ACTIVE, 8'h04}));
    beat(1'b0, 8'hA5, 10'h011);
    beat(1'b1, 8'h3C, 10'h022);
    chk("arr_keep", 64'(arr_data), 64'hA5);
    beat(1'b0, 8'h5A, 10'h033);
    @(negedge ref_clk) wr_beat = 1'b0;
    hold(1'b0, 3);
    chk("state", 64'(state), 64'(DCP_ST_ACT_PD));
    step(DCP_CMD_MRS, 1'b0, 3'h0, 14'h3FFF);
    chk("hold", 64'({state, mode_reg0}), 64'({DCP_ST_ACT_PD, 14'h0100}));
    hold(1'b1, 3);
    chk("state", 64'(state), 64'(DCP_ST_ACTIVE));
    step(DCP_CMD_ACT, 1'b1, 3'h5, 14'h0055);
    hold(1'b1, 2);
    step(DCP_CMD_PRE, 1'b1, 3'h2, 14'h0000);
    hold(1'b1, 2);
    chk("open", 64'(bank_open), 64'h20);
    step(DCP_CMD_PRE, 1'b1, 3'h0, 14'h0400);
    hold(1'b1, 2);
    chk("open", 64'(bank_open), 64'h0);
    hold(1'b0, 3);
    chk("state", 64'(state), 64'(DCP_ST_PRE_PD));
    hold(1'b1, 3);
    chk("state", 64'(state), 64'(DCP_ST_IDLE));
    $display("t_pd done");
  endtask : t_pd
  task automatic t_sr();
    @(negedge ref_clk);
    odt_req = 1'b1;
    #1;
    chk("odt", 64'(odt_active), 64'h1);
    step(DCP_CMD_REF, 1'b0, 3'h0, 14'h0000);
    hold(1'b0, 2);
    chk("sr", 64'({state, odt_active}), 64'({DCP_ST_SELF_REF, 1'b0}));
    hold(1'b1, 3);
    chk("exit", 64'({state, read_ok}), 64'({DCP_ST_IDLE, 1'b0}));
    hold(1'b1, 197);
    chk("read_ok", 64'(read_ok), 64'h0);
    hold(1'b1, 1);
    chk("read_ok", 64'(read_ok), 64'h1);
    $display("t_sr done");
  endtask : t_sr
  // Main sequence
  initial begin
    repeat (10) @(negedge ref_clk);
    srst = 1'b0;
    chk("reset", 64'({state, bank_open, read_ok, mode_reg0}), 64'({DCP_ST_IDLE, 8'h00, 1'b1,
      14'h0000}));
    $display("t_reset done");
    t_mrs();
    t_pd();
    t_sr();
    stop_test();
  end
endmodule : tb
`default_nettype wire
